//--- sxc_arb.sv
`timescale 1ns/1ps
`default_nettype none
// Fixed-priority pick of the lowest pending enabled source
module sxc_arb #(
  parameter int N = 8
) (
  input  wire logic [N-1:0]   req,
  output logic                any,
  output logic [N-1:0]        grant
);
  logic [N:0] seen;
  assign seen[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pri
      assign grant[i]  = req[i] & ~seen[i];
      assign seen[i+1] = seen[i] | req[i];
    end
  endgenerate
  assign any = seen[N];
endmodule : sxc_arb
`default_nettype wire

//--- sxc_cnt.sv
`timescale 1ns/1ps
`default_nettype none
// Free-running recovery counter with synchronous clear
module sxc_cnt
  import sxc_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         clr,
  output logic [W-1:0]      cnt
);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end
endmodule : sxc_cnt
`default_nettype wire

//--- sxc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// CPU core stand-in: instruction ends and stacking
module sxc_cpu_model #(
  parameter int STK_CYC = 3
) (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic cpu_clk_en,
  input  wire logic irq_take,
  output logic      instr_done,
  output logic      stack_done
);
  logic [3:0] ph;
  logic [3:0] stk;
  // Stacking leaves the high index byte to the handler
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ph         <= '0;
      stk        <= '0;
      instr_done <= 1'b0;
      stack_done <= 1'b0;
    end else begin
      ph         <= (cpu_clk_en && stk == 0) ? ph + 4'h1 : 4'h0;
      instr_done <= cpu_clk_en && stk == 0 && ph == 4'h3;
      stack_done <= (stk == 4'h1);
      if (irq_take) begin
        stk <= 4'(STK_CYC);
      end else if (stk != 0) begin
        stk <= stk - 4'h1;
      end
    end
  end
endmodule : sxc_cpu_model
`default_nettype wire

//--- sxc_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module sxc_ctl
  import sxc_pkg::*;
#(
  parameter int N_IRQ     = NUM_IRQ,
  parameter int LONG_CYC  = STOP_LONG_CYC,
  parameter int SHORT_CYC = STOP_SHORT_CYC
) (
  input  wire logic             clk_sys,
  input  wire logic             nrst,
  input  wire logic             rst_por,
  input  wire logic             rst_pin,
  input  wire logic             rst_wdog,
  input  wire logic             rst_ilop,
  input  wire logic             rst_ilad,
  input  wire logic             rst_lvi,
  input  wire logic [N_IRQ-1:0] irq_req,
  input  wire logic [N_IRQ-1:0] irq_en,
  input  wire logic             brk_req,
  input  wire logic             instr_done,
  input  wire logic             swi_exec,
  input  wire logic             rti_exec,
  input  wire logic             stop_exec,
  input  wire logic             wait_exec,
  input  wire logic             stack_done,
  input  wire logic             short_recovery_option,
  input  wire logic             watchdog_disable_option,
  input  wire logic [15:0]      addr,
  input  wire logic             rd_en,
  input  wire logic             wr_en,
  input  wire logic [7:0]       wdata,
  output logic [7:0]            rdata,
  output logic                  int_mask,
  output logic                  irq_take,
  output logic [VEC_W-1:0]      vec_code,
  output logic                  stack_pc_dec,
  output logic                  stack_index_hi,
  output logic                  cpu_clk_en,
  output logic                  periph_clk_en,
  output logic                  base_clock_out_en,
  output logic                  crystal_clock_en,
  output logic                  watchdog_run,
  output logic                  flag_clear_allow,
  output logic                  cnt_msb
);
  import sxc_pkg::*;

  // ==========================================================
  // State and registers
  sxc_state_t        state;
  sxc_state_t        next_state;
  logic              in_break;
  logic              latched;
  logic [N_IRQ-1:0]  latch_sel;
  logic              latch_swi;
  logic [7:0]        brk_status;
  logic [7:0]        rst_status;
  logic [7:0]        brk_ctrl;
  logic [CNT_W-1:0]  cnt;

  // ==========================================================
  // Decode and arbitration
  wire any_int_rst = rst_por | rst_wdog | rst_ilop | rst_ilad | rst_lvi;
  wire any_rst     = any_int_rst | rst_pin;
  wire [N_IRQ-1:0] hw_pend = irq_req & irq_en;
  wire             hw_any;
  wire [N_IRQ-1:0] hw_grant;
  wire sel_bs = addr == ADDR_BRK_STATUS;
  wire sel_rs = addr == ADDR_RST_STATUS;
  wire sel_bc = addr == ADDR_BRK_CTRL;
  wire [VEC_W-1:0] hw_vec;
  wire wake_irq = hw_any;
  wire wake = wake_irq | brk_req | any_rst;
  wire [CNT_W-1:0] rec_len =
    short_recovery_option ? CNT_W'(SHORT_CYC) : CNT_W'(LONG_CYC);
  wire rec_done = cnt >= rec_len - 1'b1;
  wire can_take = !latched && (instr_done || state == ST_WAIT)
                  && (hw_any && !int_mask);
  wire swi_take = !latched && (swi_exec || brk_req);

  sxc_arb #(.N(N_IRQ)) u_arb (
    .req   (hw_pend),
    .any   (hw_any),
    .grant (hw_grant)
  );

  // Vector code VEC_IRQ0 plus the index of the single granted source
  function automatic logic [VEC_W-1:0] enc(input logic [N_IRQ-1:0] g);
    logic [VEC_W-1:0] r;
    r = '0;
    for (int k = 0; k < N_IRQ; k++) begin
      if (g[k]) begin
        r = VEC_IRQ0 + VEC_W'(k);
      end
    end
    return r;
  endfunction : enc
  assign hw_vec = enc(hw_grant);

  // Counter cleared by internal reset and held through STOP
  wire cnt_clr = any_int_rst || state == ST_STOP;
  sxc_cnt #(.W(CNT_W)) u_cnt (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clr     (cnt_clr),
    .cnt     (cnt)
  );

  // ==========================================================
  // Low-power sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (stop_exec) begin
          next_state = ST_STOP;
        end else if (wait_exec) begin
          next_state = ST_WAIT;
        end else if (can_take || swi_take) begin
          next_state = ST_STACK;
        end
      end
      ST_WAIT: begin
        if (wake) begin
          next_state = any_rst ? ST_RUN : ST_STACK;
        end
      end
      ST_STOP: begin
        if (wake) begin
          next_state = any_rst ? ST_RUN : ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        if (rec_done) begin
          next_state = ST_STACK;
        end
      end
      ST_STACK: begin
        if (stack_done) begin
          next_state = ST_RUN;
        end
      end
    endcase
    if (any_rst) begin
      next_state = ST_RUN;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Interrupt latch and mask
  wire enter_stack = next_state == ST_STACK && state != ST_STACK;
  wire from_lp     = state == ST_WAIT || state == ST_RECOVER;
  wire take_brk    = brk_req && (state == ST_RUN || from_lp);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latched   <= 1'b0;
      latch_sel <= '0;
      latch_swi <= 1'b0;
      in_break  <= 1'b0;
      int_mask  <= 1'b1;
    end else if (any_rst) begin
      latched   <= 1'b0;
      latch_sel <= '0;
      latch_swi <= 1'b0;
      in_break  <= 1'b0;
      int_mask  <= 1'b1;
    end else begin
      if (enter_stack) begin
        latched   <= 1'b1;
        latch_swi <= swi_take || take_brk;
        latch_sel <= (swi_take || take_brk) ? '0 : hw_grant;
        int_mask  <= 1'b1;
        if (brk_req) begin
          in_break <= 1'b1;
        end
      end else if (stop_exec || wait_exec) begin
        int_mask <= 1'b0;
      end else if (rti_exec) begin
        int_mask <= 1'b0;
        in_break <= 1'b0;
      end
      if (state == ST_STACK && stack_done) begin
        latched <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Registers
  wire bs_clr_wr = sel_bs && wr_en && !wdata[BIT_BREAK_EXIT];
  wire bs_set = brk_req && (state == ST_WAIT || state == ST_STOP);
  wire [7:0] rst_src = {rst_por, rst_pin, rst_wdog, rst_ilop,
                        rst_ilad, 1'b0, rst_lvi, 1'b0};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      brk_status <= RST_BRK_STATUS;
      rst_status <= RST_RST_STATUS;
      brk_ctrl   <= RST_BRK_CTRL;
    end else begin
      if (any_rst) begin
        brk_status <= RST_BRK_STATUS;
        brk_ctrl   <= RST_BRK_CTRL;
      end else begin
        if (bs_set) begin
          brk_status[BIT_BREAK_EXIT] <= 1'b1;
        end else if (bs_clr_wr) begin
          brk_status[BIT_BREAK_EXIT] <= 1'b0;
        end
        if (sel_bc && wr_en) begin
          brk_ctrl[BIT_BREAK_CLEAR] <= wdata[BIT_BREAK_CLEAR];
        end
      end
      if (rst_por) begin
        rst_status <= RST_RST_STATUS;
      end else if (any_rst) begin
        rst_status <= rst_status | rst_src;
      end else if (sel_rs && rd_en) begin
        rst_status <= '0;
      end
    end
  end

  // ==========================================================
  // Registered outputs
  wire [7:0] next_rdata = sel_bs ? brk_status :
                          sel_rs ? rst_status :
                          sel_bc ? brk_ctrl   : 8'h00;
  wire in_stop = next_state == ST_STOP || next_state == ST_RECOVER;
  wire in_lp   = next_state == ST_WAIT || in_stop;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata             <= 8'h00;
      irq_take          <= 1'b0;
      vec_code          <= VEC_RESET;
      stack_pc_dec      <= 1'b0;
      stack_index_hi    <= 1'b0;
      cpu_clk_en        <= 1'b1;
      periph_clk_en     <= 1'b1;
      base_clock_out_en <= 1'b1;
      crystal_clock_en  <= 1'b1;
      watchdog_run      <= 1'b1;
      flag_clear_allow  <= 1'b1;
      cnt_msb           <= 1'b0;
    end else begin
      rdata    <= rd_en ? next_rdata : 8'h00;
      irq_take <= enter_stack;
      if (any_rst) begin
        vec_code <= VEC_RESET;
      end else if (enter_stack) begin
        vec_code <= (swi_take || take_brk) ? VEC_SWI : hw_vec;
        stack_pc_dec <= !(swi_take || take_brk);
      end
      stack_index_hi    <= 1'b0;
      cpu_clk_en        <= !in_lp;
      periph_clk_en     <= !in_stop;
      base_clock_out_en <= next_state != ST_STOP;
      crystal_clock_en  <= next_state != ST_STOP;
      watchdog_run      <= !watchdog_disable_option
                           && !in_stop;
      flag_clear_allow  <= !(in_break || enter_stack && brk_req)
                           || brk_ctrl[BIT_BREAK_CLEAR];
      cnt_msb           <= cnt[CNT_W-1];
    end
  end

  // ==========================================================
  // Checks
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  a_stop_counter_held: assert property (
    state == ST_STOP |=> cnt == '0)
    else $error("counter not held in stop");
  a_pin_no_clear: assert property (
    rst_pin && !any_int_rst && state != ST_STOP && cnt != '1
      |=> cnt == $past(cnt) + 1'b1)
    else $error("pin reset disturbed counter");
  a_entry_masks: assert property (
    enter_stack && !any_rst |=> int_mask && irq_take)
    else $error("entry did not set mask");
  a_swi_vector: assert property (
    enter_stack && !any_rst && (swi_exec || brk_req)
      |=> vec_code == VEC_SWI && !stack_pc_dec)
    else $error("software entry wrong vector");
  a_reset_wins: assert property (
    any_rst |=> vec_code == VEC_RESET && state == ST_RUN)
    else $error("reset not highest");
  a_latch_holds: assert property (
    latched && !any_rst && !(state == ST_STACK && stack_done)
      |=> $stable(latch_sel))
    else $error("latched interrupt preempted");
  a_brk_exit_flag: assert property (
    bs_set && !any_rst |=> brk_status[BIT_BREAK_EXIT])
    else $error("break exit flag not set");
  a_stop_clocks_off: assert property (
    state == ST_STOP |-> !base_clock_out_en && !crystal_clock_en)
    else $error("clocks running in stop");
  a_short_recover: assert property (
    state == ST_RECOVER && short_recovery_option && !any_rst
      |-> cnt < CNT_W'(SHORT_CYC))
    else $error("short recovery overran");
  a_rs_read_clear: assert property (
    sel_rs && rd_en && !any_rst |=> rst_status == 8'h00)
    else $error("reset status not cleared");
  c_wait_wake: cover property (state == ST_WAIT ##1 state == ST_STACK);
  c_stop_recover: cover property (state == ST_RECOVER ##1 state == ST_STACK);
  c_break_entry: cover property (enter_stack && brk_req);
endmodule : sxc_ctl
`default_nettype wire

//--- sxc_pkg.sv
package sxc_pkg;
  // =====================================
  // Register map
  localparam logic [15:0] ADDR_BRK_STATUS = 16'hfe00;
  localparam logic [15:0] ADDR_RST_STATUS = 16'hfe01;
  localparam logic [15:0] ADDR_BRK_CTRL   = 16'hfe03;
  // =====================================
  // Field positions
  localparam int BIT_BREAK_EXIT   = 1;
  localparam int BIT_BREAK_CLEAR  = 7;
  localparam int RS_LVI  = 1;
  localparam int RS_ILAD = 3;
  localparam int RS_ILOP = 4;
  localparam int RS_WDOG = 5;
  localparam int RS_PIN  = 6;
  localparam int RS_POR  = 7;
  // =====================================
  // Reset values
  localparam logic [7:0] RST_BRK_STATUS = 8'h00;
  localparam logic [7:0] RST_RST_STATUS = 8'h80;
  localparam logic [7:0] RST_BRK_CTRL   = 8'h00;
  // =====================================
  // Timing, in crystal-clock cycles
  localparam int CNT_W          = 13;
  localparam int STOP_LONG_CYC  = 4096;
  localparam int STOP_SHORT_CYC = 32;
  // =====================================
  // Vector selection codes
  localparam int NUM_IRQ = 8;
  localparam int VEC_W   = 4;
  localparam logic [3:0] VEC_RESET = 4'h0;
  localparam logic [3:0] VEC_SWI   = 4'h1;
  localparam logic [3:0] VEC_IRQ0  = 4'h2;

  typedef enum logic [2:0] {
    ST_RUN, ST_WAIT, ST_STOP, ST_RECOVER, ST_STACK
  } sxc_state_t;
endpackage : sxc_pkg

//--- tb_sim_exception_lowpower_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sim_exception_lowpower_ctl;
  import sxc_pkg::*;
  localparam int LONG  = 64;
  localparam int SHORT = 32;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        rst_por, rst_pin, rst_wdog, rst_ilop, rst_ilad, rst_lvi;
  logic        swi_exec, rti_exec, stop_exec, wait_exec, brk_req;
  logic        rd_en, wr_en, rd_seen, short_recovery_option;
  logic        watchdog_disable_option, instr_done, stack_done;
  logic        int_mask, irq_take, stack_pc_dec, stack_index_hi;
  logic        cpu_clk_en, periph_clk_en, base_clock_out_en;
  logic        crystal_clock_en, watchdog_run, flag_clear_allow, cnt_msb;
  logic [7:0]  irq_req, irq_en, wdata, rdata, e8, w8;
  logic [15:0] addr;
  logic [VEC_W-1:0] vec_code;
  logic [15:0] rq[$];
  logic [7:0]  tq[$];
  int          fails = 0;
  int          samples_checked = 0;
  int          seed = 32'hbf14;
  int          n;
  int          k;

  always #5 clk_sys = ~clk_sys;

  sxc_ctl #(.LONG_CYC(LONG), .SHORT_CYC(SHORT)) DUT (
    .clk_sys, .nrst, .rst_por, .rst_pin, .rst_wdog, .rst_ilop,
    .rst_ilad, .rst_lvi, .irq_req, .irq_en, .brk_req, .instr_done,
    .swi_exec, .rti_exec, .stop_exec, .wait_exec, .stack_done,
    .short_recovery_option, .watchdog_disable_option, .addr, .rd_en,
    .wr_en, .wdata, .rdata, .int_mask, .irq_take, .vec_code,
    .stack_pc_dec, .stack_index_hi, .cpu_clk_en, .periph_clk_en,
    .base_clock_out_en, .crystal_clock_en, .watchdog_run,
    .flag_clear_allow, .cnt_msb
  );

  sxc_cpu_model cpu (
    .clk_sys, .nrst, .cpu_clk_en, .irq_take, .instr_done, .stack_done
  );

  task automatic print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  // Strobes: swi, rti, stop, wait, then the six reset sources
  task automatic cmd(input logic [9:0] v);
    @(posedge clk_sys);
    {swi_exec, rti_exec, stop_exec, wait_exec, rst_por, rst_pin,
     rst_wdog, rst_ilop, rst_ilad, rst_lvi} <= v;
    @(posedge clk_sys);
    {swi_exec, rti_exec, stop_exec, wait_exec, rst_por, rst_pin,
     rst_wdog, rst_ilop, rst_ilad, rst_lvi} <= '0;
    repeat (2) @(posedge clk_sys);
  endtask : cmd

  task automatic rd(input logic [15:0] a, input logic [7:0] e, m);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    rq.push_back({e & m, m});
    @(posedge clk_sys);
    rd_en <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  // Bounded wait for a level; count of cycles lands in n
  task automatic wait_on(input string nm, ref logic s, input int lim);
    for (n = 1; n <= lim; n++) begin
      @(posedge clk_sys);
      if (s === 1'b1) return;
    end
    $display("unexpected %s expected 1 seen timeout", nm);
    fails++;
    print_verdict();
  endtask : wait_on

  // ========================================
  // Result watcher: oldest note against each answer
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      if (rq.size() == 0) chk("rdata", 8'h00, 8'hff);
      else begin
        w8 = rq[0][7:0];
        chk("rdata", rq[0][15:8], rdata & w8);
        void'(rq.pop_front());
      end
    end
    rd_seen <= rd_en;
    if (irq_take === 1'b1) begin
      if (tq.size() == 0) chk("irq_take", 8'h00, 8'h01);
      else begin
        w8 = tq.pop_front();
        chk("vec_code", {4'h0, w8[3:0]}, {4'h0, vec_code});
        chk("stack_pc_dec", {7'h0, w8[7]}, {7'h0, stack_pc_dec});
        chk("int_mask", 8'h01, {7'h0, int_mask});
      end
    end
  end

  initial begin
    {rst_por, rst_pin, rst_wdog, rst_ilop, rst_ilad, rst_lvi} = '0;
    {swi_exec, rti_exec, stop_exec, wait_exec, brk_req} = '0;
    {rd_en, wr_en, rd_seen, short_recovery_option} = '0;
    {watchdog_disable_option, irq_req, irq_en, wdata, addr} = '0;
    repeat (10) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("stack_index_hi", 8'h00, {7'h0, stack_index_hi});
    rd(ADDR_BRK_STATUS, 8'h00, 8'hff);
    rd(ADDR_RST_STATUS, 8'h80, 8'hff);
    rd(ADDR_RST_STATUS, 8'h00, 8'hff);
    rd(16'hfe02, 8'h00, 8'hff);
    wr(ADDR_BRK_CTRL, 8'hff);
    rd(ADDR_BRK_CTRL, 8'h80, 8'hff);
    wr(ADDR_BRK_CTRL, 8'h00);
    $display("test registers done");
    wait_on("cnt_msb", cnt_msb, 5000);
    cmd(10'h010);
    chk("cnt_msb", 8'h01, {7'h0, cnt_msb});
    for (k = 0; k < 6; k++) begin
      cmd(10'h020 >> k);
      e8 = 8'(48'h80_40_20_10_08_02 >> (40 - 8 * k));
      rd(ADDR_RST_STATUS, e8, (k == 0) ? 8'hff : e8);
      chk("vec_code", 8'h00, {4'h0, vec_code});
      if (k > 1) chk("cnt_msb", 8'h00, {7'h0, cnt_msb});
    end
    $display("test resets done");
    repeat (4) begin
      watchdog_disable_option <= 1'($random(seed));
      cmd(10'h040);
      chk("cpu_clk_en", 8'h00, {7'h0, cpu_clk_en});
      chk("periph_clk_en", 8'h01, {7'h0, periph_clk_en});
      chk("int_mask", 8'h00, {7'h0, int_mask});
      chk("watchdog_run", {7'h0, !watchdog_disable_option},
          {7'h0, watchdog_run});
      e8 = $random(seed);
      e8[7] = 1'b1;
      irq_req <= e8;
      irq_en  <= $random(seed) | 8'h80;
      @(posedge clk_sys);
      for (k = 7; k >= 0; k--) if (irq_req[k] && irq_en[k]) n = k;
      tq.push_back({4'h8, 4'(2 + n)});
      wait_on("irq_take", irq_take, 20);
      irq_req <= '0;
      wait_on("stack_done", stack_done, 20);
    end
    $display("test wait wakeup done");
    irq_req <= 8'h01;
    irq_en  <= 8'hff;
    repeat (20) @(posedge clk_sys);
    chk("int_mask", 8'h01, {7'h0, int_mask});
    irq_req <= '0;
    tq.push_back({4'h0, VEC_SWI});
    cmd(10'h200);
    wait_on("stack_done", stack_done, 20);
    $display("test masking done");
    for (k = 0; k < 2; k++) begin
      short_recovery_option <= (k == 0);
      cmd(10'h080);
      chk("base_clk_en", 8'h00, {7'h0, base_clock_out_en});
      chk("xtal_clk_en", 8'h00, {7'h0, crystal_clock_en});
      tq.push_back({4'h8, VEC_IRQ0});
      irq_req <= 8'h01;
      irq_en  <= 8'h01;
      wait_on("irq_take", irq_take, 200);
      e8 = (n >= (k ? LONG : SHORT)) && (n <= (k ? LONG : SHORT) + 8);
      chk("recovery", 8'h01, e8);
      irq_req <= '0;
      wait_on("stack_done", stack_done, 20);
    end
    $display("test stop recovery done");
    cmd(10'h040);
    tq.push_back({4'h0, VEC_SWI});
    brk_req <= 1'b1;
    wait_on("irq_take", irq_take, 20);
    brk_req <= 1'b0;
    chk("flag_clear", 8'h00, {7'h0, flag_clear_allow});
    wait_on("stack_done", stack_done, 20);
    rd(ADDR_BRK_STATUS, 8'h02, 8'h02);
    wr(ADDR_BRK_CTRL, 8'h80);
    repeat (2) @(posedge clk_sys);
    chk("flag_clear", 8'h01, {7'h0, flag_clear_allow});
    wr(ADDR_BRK_CTRL, 8'h00);
    repeat (2) @(posedge clk_sys);
    chk("flag_clear", 8'h00, {7'h0, flag_clear_allow});
    cmd(10'h100);
    chk("flag_clear", 8'h01, {7'h0, flag_clear_allow});
    wr(ADDR_BRK_STATUS, 8'h00);
    rd(ADDR_BRK_STATUS, 8'h00, 8'h02);
    $display("test break done");
    repeat (5) @(posedge clk_sys);
    print_verdict();
  end
endmodule : tb_sim_exception_lowpower_ctl
`default_nettype wire
